// ### hdl/orc_config_map.vh
`ifndef ORC_CONFIG_MAP_VH
`define ORC_CONFIG_MAP_VH

// spi word layout
`define ORC_BANK_BIT 13
`define ORC_ADDR_HI 12
`define ORC_ADDR_LO 10
`define ORC_DATA_HI 8
`define ORC_DATA_LO 0
`define ORC_ADDR_OCR 3'h4
`define ORC_ADDR_RETRY 3'h5
`define ORC_REG_RESET 9'h000

// overcurrent_config fields
`define ORC_OCR_HIGH_RANGE 8
`define ORC_OCR_PRESCALE 7
`define ORC_OCR_INT_CLOCK 6
`define ORC_OCR_SENSE_RATIO 5
`define ORC_OCR_HIGH_WIN 4
`define ORC_OCR_MID_WIN 3
`define ORC_OCR_UPPER_THR 2
`define ORC_OCR_MID_THR 1
`define ORC_OCR_LOWER_THR 0

// auto_retry_config fields
`define ORC_RTY_OFFSET_POL 8
`define ORC_RTY_LOAD_INVERT 4
`define ORC_RTY_PERIOD_HI 3
`define ORC_RTY_PERIOD_LO 2
`define ORC_RTY_UNLIMITED 1
`define ORC_RTY_ENABLE 0

// lower threshold level codes
`define ORC_LOW_LVL1 2'h0
`define ORC_LOW_LVL2 2'h1
`define ORC_LOW_LVL3 2'h2

// dividers and limits
`define ORC_PRESCALE_LONG 9'h1FF
`define ORC_PRESCALE_SHORT 9'h0FF
`define ORC_RETRY_LIMIT 5'h10
`define ORC_INT_CLK_DIV 8'hC3

`endif

// ### hdl/orc_prescaler.v
`timescale 1ns/1ns
`include "orc_config_map.vh"

module orc_prescaler (
   core_clk,
   sys_rst,
   extEdge,
   divLong,
   tick
);
   input wire core_clk;
   input wire sys_rst;
   input wire extEdge;
   input wire divLong;
   output reg tick;

   reg [8:0] count_reg;
   wire [8:0] terminal;

   // divide by 512 when long, else by 256
   assign terminal = divLong ? `ORC_PRESCALE_LONG : `ORC_PRESCALE_SHORT;

   always @(posedge core_clk) begin
      if (sys_rst) begin
         count_reg <= 9'h000;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (extEdge) begin
            // a switch to the short divider past count 255 ends the period on the next edge
            if (count_reg >= terminal) begin
               count_reg <= 9'h000;
               tick <= 1'b1;
            end else begin
               count_reg <= count_reg + 9'h001;
            end
         end
      end
   end
endmodule // orc_prescaler

// ### hdl/orc_overcurrent_retry.v
`timescale 1ns/1ns
`include "orc_config_map.vh"

module orc_overcurrent_retry #(
   parameter CHANNELS = 2,
   parameter [7:0] INT_CLK_DIV = `ORC_INT_CLK_DIV
) (
   core_clk,
   sys_rst,
   frameValid,
   frameWord,
   loadTypePin,
   extClockPin,
   ocWindowActive,
   retryAttempt,
   retryCounterClear,
   overcurrentConfig,
   autoRetryConfig,
   bulbProfile,
   middleThresholdActive,
   upperThresholdSel,
   middleThresholdSel,
   lowerThresholdLevel,
   thresholdScaleDown,
   senseRatioSel,
   windowSel,
   useInternalClock,
   pwmTick,
   senseOutputEnable,
   senseOffsetAdd,
   retryPeriodSel,
   retryEnable,
   retryAllowed,
   retryFull
);
   input wire core_clk;
   input wire sys_rst;
   input wire frameValid;
   input wire [15:0] frameWord;
   input wire [CHANNELS-1:0] loadTypePin;
   input wire extClockPin;
   input wire [CHANNELS-1:0] ocWindowActive;
   input wire [CHANNELS-1:0] retryAttempt;
   input wire [CHANNELS-1:0] retryCounterClear;
   output wire [9*CHANNELS-1:0] overcurrentConfig;
   output wire [9*CHANNELS-1:0] autoRetryConfig;
   output wire [CHANNELS-1:0] bulbProfile;
   output wire [CHANNELS-1:0] middleThresholdActive;
   output wire [CHANNELS-1:0] upperThresholdSel;
   output wire [CHANNELS-1:0] middleThresholdSel;
   output wire [2*CHANNELS-1:0] lowerThresholdLevel;
   output wire [CHANNELS-1:0] thresholdScaleDown;
   output wire [CHANNELS-1:0] senseRatioSel;
   output wire [2*CHANNELS-1:0] windowSel;
   output wire [CHANNELS-1:0] useInternalClock;
   output wire [CHANNELS-1:0] pwmTick;
   output wire [CHANNELS-1:0] senseOutputEnable;
   output wire [CHANNELS-1:0] senseOffsetAdd;
   output wire [2*CHANNELS-1:0] retryPeriodSel;
   output wire [CHANNELS-1:0] retryEnable;
   output wire [CHANNELS-1:0] retryAllowed;
   output wire [CHANNELS-1:0] retryFull;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and shared timing

   reg [CHANNELS-1:0] loadMeta_reg;
   reg [CHANNELS-1:0] loadSync_reg;
   reg extMeta_reg;
   reg extSync_reg;
   reg extLast_reg;
   reg [7:0] intDiv_reg;
   reg intTick_reg;
   wire extEdge;
   wire [2:0] frameAddr;

   assign extEdge = extSync_reg & ~extLast_reg;
   assign frameAddr = frameWord[`ORC_ADDR_HI:`ORC_ADDR_LO];

   always @(posedge core_clk) begin
      if (sys_rst) begin
         loadMeta_reg <= {CHANNELS{1'b0}};
         loadSync_reg <= {CHANNELS{1'b0}};
         extMeta_reg <= 1'b0;
         extSync_reg <= 1'b0;
         extLast_reg <= 1'b0;
      end else begin
         loadMeta_reg <= loadTypePin;
         loadSync_reg <= loadMeta_reg;
         extMeta_reg <= extClockPin;
         extSync_reg <= extMeta_reg;
         extLast_reg <= extSync_reg;
      end
   end

   // internal PWM step clock, one enable pulse per INT_CLK_DIV cycles
   always @(posedge core_clk) begin
      if (sys_rst) begin
         intDiv_reg <= 8'h00;
         intTick_reg <= 1'b0;
      end else if (intDiv_reg >= INT_CLK_DIV - 8'h01) begin
         intDiv_reg <= 8'h00;
         intTick_reg <= 1'b1;
      end else begin
         intDiv_reg <= intDiv_reg + 8'h01;
         intTick_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-channel register bank and decode

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : bank
         reg [8:0] ocr_reg;
         reg [8:0] rty_reg;
         reg [4:0] retryCount_reg;
         reg bulb_reg;
         reg midAct_reg;
         reg upper_reg;
         reg middle_reg;
         reg [1:0] lower_reg;
         reg ratio_reg;
         reg [1:0] win_reg;
         reg intClk_reg;
         reg tick_reg;
         reg senseEn_reg;
         reg offAdd_reg;
         reg [1:0] period_reg;
         reg rtyEn_reg;
         reg allowed_reg;
         reg full_reg;
         wire bankHit;
         wire profileMotor;
         wire retryOn;
         wire [4:0] retryCount_next;
         wire extTick;
         wire bankSel;
         wire ocrWrite;
         wire rtyWrite;

         // one bank bit, so only two channels can be told apart
         assign bankSel = (ch == 0) ? ~frameWord[`ORC_BANK_BIT] :
            frameWord[`ORC_BANK_BIT];
         // write only on a complete frame for this bank
         assign bankHit = frameValid & bankSel;
         assign ocrWrite = bankHit & (frameAddr == `ORC_ADDR_OCR);
         assign rtyWrite = bankHit & (frameAddr == `ORC_ADDR_RETRY);
         // profile follows pin, optionally inverted
         assign profileMotor = loadSync_reg[ch] ^
            rty_reg[`ORC_RTY_LOAD_INVERT];
         // enable polarity flips with the profile
         assign retryOn = profileMotor ? rty_reg[`ORC_RTY_ENABLE] :
            ~rty_reg[`ORC_RTY_ENABLE];

         always @(posedge core_clk) begin
            if (sys_rst) begin
               ocr_reg <= `ORC_REG_RESET;
               rty_reg <= `ORC_REG_RESET;
            end else begin
               if (ocrWrite)
                  ocr_reg <= frameWord[`ORC_DATA_HI:`ORC_DATA_LO];
               if (rtyWrite)
                  rty_reg <= frameWord[`ORC_DATA_HI:`ORC_DATA_LO];
            end
         end

         ////////////////////////////////////////////////////////////////
         // retry counter
         // saturates at the limit; unlimited mode stops counting there
         // since nothing downstream needs more than the full flag
         assign retryCount_next = (retryCount_reg == `ORC_RETRY_LIMIT) ?
            retryCount_reg : retryCount_reg + 5'h01;

         // only reset or an explicit clear empties it, never a delatch
         always @(posedge core_clk) begin
            if (sys_rst | retryCounterClear[ch])
               retryCount_reg <= 5'h00;
            else if (retryAttempt[ch] & allowed_reg)
               retryCount_reg <= retryCount_next;
         end

         // one divider per channel keeps the two prescale bits independent
         orc_prescaler u_prescaler (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .extEdge(extEdge),
            .divLong(ocr_reg[`ORC_OCR_PRESCALE]),
            .tick(extTick)
         );

         ////////////////////////////////////////////////////////////////
         // threshold decode
         always @(posedge core_clk) begin
            if (sys_rst) begin
               bulb_reg <= 1'b1;
               midAct_reg <= 1'b0;
               upper_reg <= 1'b0;
               middle_reg <= 1'b0;
               lower_reg <= `ORC_LOW_LVL1;
               ratio_reg <= 1'b0;
            end else begin
               bulb_reg <= ~profileMotor;
               midAct_reg <= ~profileMotor;
               upper_reg <= ocr_reg[`ORC_OCR_UPPER_THR];
               middle_reg <= ~profileMotor &
                  ocr_reg[`ORC_OCR_MID_THR];
               if (~ocr_reg[`ORC_OCR_HIGH_RANGE])
                  lower_reg <= `ORC_LOW_LVL1;
               else if (ocr_reg[`ORC_OCR_LOWER_THR])
                  lower_reg <= `ORC_LOW_LVL3;
               else
                  lower_reg <= `ORC_LOW_LVL2;
               ratio_reg <= ocr_reg[`ORC_OCR_SENSE_RATIO];
            end
         end

         // window and PWM step source
         always @(posedge core_clk) begin
            if (sys_rst) begin
               win_reg <= 2'h0;
               intClk_reg <= 1'b0;
               tick_reg <= 1'b0;
            end else begin
               // same two bits, meaning set by the profile
               win_reg <= {ocr_reg[`ORC_OCR_HIGH_WIN],
                  ocr_reg[`ORC_OCR_MID_WIN]};
               intClk_reg <= ocr_reg[`ORC_OCR_INT_CLOCK];
               tick_reg <= ocr_reg[`ORC_OCR_INT_CLOCK] ?
                  intTick_reg : extTick;
            end
         end

         // sense path controls
         always @(posedge core_clk) begin
            if (sys_rst) begin
               senseEn_reg <= 1'b0;
               offAdd_reg <= 1'b0;
            end else begin
               senseEn_reg <= ~ocWindowActive[ch];
               offAdd_reg <= rty_reg[`ORC_RTY_OFFSET_POL];
            end
         end

         // retry status, one cycle behind the counter
         always @(posedge core_clk) begin
            if (sys_rst) begin
               period_reg <= 2'h0;
               rtyEn_reg <= 1'b0;
               allowed_reg <= 1'b0;
               full_reg <= 1'b0;
            end else begin
               period_reg <= {rty_reg[`ORC_RTY_PERIOD_HI],
                  rty_reg[`ORC_RTY_PERIOD_LO]};
               rtyEn_reg <= retryOn;
               allowed_reg <= retryOn &
                  (rty_reg[`ORC_RTY_UNLIMITED] |
                  (retryCount_reg != `ORC_RETRY_LIMIT));
               full_reg <= (retryCount_reg == `ORC_RETRY_LIMIT);
            end
         end

         assign overcurrentConfig[9*ch+8:9*ch] = ocr_reg;
         assign autoRetryConfig[9*ch+8:9*ch] = rty_reg;
         assign bulbProfile[ch] = bulb_reg;
         assign middleThresholdActive[ch] = midAct_reg;
         assign upperThresholdSel[ch] = upper_reg;
         assign middleThresholdSel[ch] = middle_reg;
         assign lowerThresholdLevel[2*ch+1:2*ch] = lower_reg;
         assign thresholdScaleDown[ch] = ratio_reg;
         assign senseRatioSel[ch] = ratio_reg;
         assign windowSel[2*ch+1:2*ch] = win_reg;
         assign useInternalClock[ch] = intClk_reg;
         assign pwmTick[ch] = tick_reg;
         assign senseOutputEnable[ch] = senseEn_reg;
         assign senseOffsetAdd[ch] = offAdd_reg;
         assign retryPeriodSel[2*ch+1:2*ch] = period_reg;
         assign retryEnable[ch] = rtyEn_reg;
         assign retryAllowed[ch] = allowed_reg;
         assign retryFull[ch] = full_reg;
      end
   endgenerate
endmodule // orc_overcurrent_retry

// ### sim/orc_checker.sv
`timescale 1ns/1ns
module orc_checker (
   input logic core_clk,
   input logic sys_rst,
   input logic frameValid,
   input logic [15:0] frameWord,
   input logic [1:0] ocWindowActive,
   input logic [17:0] overcurrentConfig,
   input logic [17:0] autoRetryConfig,
   input logic [1:0] upperThresholdSel,
   input logic [3:0] lowerThresholdLevel,
   input logic [1:0] thresholdScaleDown,
   input logic [1:0] senseRatioSel,
   input logic [3:0] windowSel,
   input logic [1:0] senseOutputEnable,
   input logic [1:0] senseOffsetAdd,
   input logic [1:0] retryAllowed,
   input logic [1:0] retryFull
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////
   ocr_store_a:
   assert property (frameValid && frameWord[13:10] == 4'h4
      |=> overcurrentConfig[8:0] == $past(frameWord[8:0]))
      else $error("ocr0 write lost");
   rty_store_a:
   assert property (frameValid && frameWord[13:10] == 4'hD
      |=> autoRetryConfig[17:9] == $past(frameWord[8:0]))
      else $error("rty1 write lost");
   ratio_dec_a:
   assert property (senseRatioSel[0] == $past(overcurrentConfig[5]))
      else $error("ratio select wrong");
   scale_tie_a:
   assert property (thresholdScaleDown[1] == $past(overcurrentConfig[14]))
      else $error("scale select wrong");
   low_level_a:
   assert property (lowerThresholdLevel[1:0] == {$past(overcurrentConfig[8])
      & $past(overcurrentConfig[0]), $past(overcurrentConfig[8])
      & !$past(overcurrentConfig[0])})
      else $error("lower level wrong");
   upper_sel_a:
   assert property (upperThresholdSel[1] == $past(overcurrentConfig[11]))
      else $error("upper select wrong");
   win_sel_a:
   assert property (windowSel[3:2] == $past(overcurrentConfig[13:12]))
      else $error("window select wrong");
   offset_pol_a:
   assert property ($rose(autoRetryConfig[8]) |=> senseOffsetAdd[0])
      else $error("offset polarity wrong");
   sense_gate_a:
   assert property (ocWindowActive[0] |=> !senseOutputEnable[0])
      else $error("sense open in window");
   retry_cap_a:
   assert property (retryFull[0] && !$past(autoRetryConfig[1])
      |-> !retryAllowed[0])
      else $error("retry beyond cap");
   cover property (retryFull[0]);
   cover property (frameValid && frameWord[12:10] == 3'h5);
   cover property (ocWindowActive[1] ##1 !ocWindowActive[1]);
endmodule // orc_checker

// ### sim/orc_mcu_model.sv
`timescale 1ns/1ns
module orc_mcu_model (
   input logic core_clk,
   output logic frameValid,
   output logic [15:0] frameWord
);
   initial begin
      frameValid = 1'b0;
      frameWord = 16'h0000;
   end
   // stale word is inverted so a late sample cannot pass by luck
   task automatic send(input logic [15:0] w);
      @(negedge core_clk);
      frameWord = w;
      frameValid = 1'b1;
      @(negedge core_clk);
      frameValid = 1'b0;
      frameWord = ~w;
   endtask
endmodule // orc_mcu_model

// ### sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic core_clk, sys_rst, extClockPin, bulb;
   wire frameValid;
   wire [15:0] frameWord;
   logic [1:0] loadTypePin, ocWindowActive, retryAttempt, retryCounterClear;
   wire [17:0] overcurrentConfig, autoRetryConfig;
   wire [3:0] lowerThresholdLevel, windowSel, retryPeriodSel;
   wire [1:0] bulbProfile, middleThresholdActive, upperThresholdSel;
   wire [1:0] middleThresholdSel, thresholdScaleDown, senseRatioSel;
   wire [1:0] useInternalClock, pwmTick, senseOutputEnable, senseOffsetAdd;
   wire [1:0] retryEnable, retryAllowed, retryFull;
   integer n_mismatch = 0, cmp_count = 0, cycles = 0, seed = 32'h84C1;
   integer i, ch, tk0, tk1;
   logic [8:0] ocr [2];
   logic [8:0] rty [2];
   logic [15:0] w;
   orc_overcurrent_retry #(.INT_CLK_DIV(8'h04)) uut (.*);
   orc_mcu_model mcu (.core_clk(core_clk), .frameValid(frameValid),
      .frameWord(frameWord));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch = n_mismatch + 1;
         finish_test;
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [8:0] e, g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task finish_test;
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic do_reset;
      sys_rst = 1'b1;
      repeat (3) @(negedge core_clk);
      sys_rst = 1'b0;
      ocr = '{9'h000, 9'h000};
      rty = '{9'h000, 9'h000};
   endtask
   task automatic wr(input logic b, a, input logic [8:0] d);
      if (a) rty[b] = d;
      else ocr[b] = d;
      mcu.send({2'h0, b, 2'h2, a, 1'b0, d});
   endtask
   // six cycles cover the pin synchroniser as well as decode latency
   task automatic check_all;
      repeat (6) @(negedge core_clk);
      for (ch = 0; ch < 2; ch++) begin
         bulb = ~(loadTypePin[ch] ^ rty[ch][4]);
         chk("ocr", ocr[ch], overcurrentConfig[9*ch +: 9]);
         chk("rty", rty[ch], autoRetryConfig[9*ch +: 9]);
         chk("bulb", bulb, bulbProfile[ch]);
         chk("midact", bulb, middleThresholdActive[ch]);
         chk("midsel", bulb & ocr[ch][1], middleThresholdSel[ch]);
         chk("low", {ocr[ch][8] & ocr[ch][0],
            ocr[ch][8] & ~ocr[ch][0]}, lowerThresholdLevel[2*ch +: 2]);
         chk("scale", ocr[ch][5], thresholdScaleDown[ch]);
         chk("ratio", ocr[ch][5], senseRatioSel[ch]);
         chk("win", ocr[ch][4:3], windowSel[2*ch +: 2]);
         chk("upper", ocr[ch][2], upperThresholdSel[ch]);
         chk("intclk", ocr[ch][6], useInternalClock[ch]);
         chk("offset", rty[ch][8], senseOffsetAdd[ch]);
         chk("period", rty[ch][3:2], retryPeriodSel[2*ch +: 2]);
         chk("rten", bulb ^ rty[ch][0], retryEnable[ch]);
      end
   endtask
   task automatic attempts(input integer n);
      retryAttempt = 2'h1;
      repeat (n) @(negedge core_clk);
      retryAttempt = 2'h0;
      retryCounterClear = 2'h0;
      repeat (3) @(negedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      extClockPin = 1'b0;
      loadTypePin = 2'h0;
      ocWindowActive = 2'h0;
      retryAttempt = 2'h0;
      retryCounterClear = 2'h0;
      do_reset;
      check_all;
      for (i = 0; i < 8; i++) begin
         loadTypePin = 2'h3;
         wr(1'b0, 1'b0, {i[2], 3'h0, i[1:0], 2'h0, i[0]});
         wr(1'b0, 1'b1, {i[1], 3'h0, i[2], i[1:0], i[2], i[0]});
         wr(1'b1, i[0], {i[2:0], ~i[2:0], i[2:0]});
         check_all;
      end
      // unmapped addresses are mixed in and must leave both banks alone
      for (i = 0; i < 24; i++) begin
         w = 16'($random(seed));
         if (w[9]) w[12:11] = 2'h2;
         if (w[12:11] == 2'h2) begin
            if (w[10]) rty[w[13]] = w[8:0];
            else ocr[w[13]] = w[8:0];
         end
         loadTypePin = w[15:14];
         mcu.send(w);
         check_all;
      end
      loadTypePin = 2'h0;
      do_reset;
      check_all;
      attempts(15);
      chk("fa15", 9'h001, {retryFull[0], retryAllowed[0]});
      attempts(5);
      ocWindowActive = 2'h3;
      repeat (3) @(negedge core_clk);
      chk("gate", 9'h000, senseOutputEnable);
      ocWindowActive = 2'h0;
      repeat (3) @(negedge core_clk);
      chk("gate", 9'h003, senseOutputEnable);
      chk("fa16", 9'h002, {retryFull[0], retryAllowed[0]});
      wr(1'b0, 1'b1, 9'h002);
      repeat (3) @(negedge core_clk);
      chk("faunl", 9'h003, {retryFull[0], retryAllowed[0]});
      retryCounterClear = 2'h1;
      attempts(1);
      chk("faclr", 9'h001, {retryFull[0], retryAllowed[0]});
      wr(1'b0, 1'b1, 9'h001);
      attempts(2);
      chk("fadis", 9'h000, {retryFull[0], retryAllowed[0]});
      wr(1'b1, 1'b0, 9'h080);
      tk0 = 0;
      tk1 = 0;
      for (i = 0; i < 4112; i++) begin
         @(negedge core_clk);
         retryCounterClear = 2'h0;
         extClockPin = (i < 4096) ? i[1] : 1'b0;
         tk0 += pwmTick[0];
         tk1 += pwmTick[1];
      end
      chk("tk256", 9'h004, tk0[8:0]);
      chk("tk512", 9'h002, tk1[8:0]);
      wr(1'b1, 1'b0, 9'h040);
      repeat (4) @(negedge core_clk);
      tk1 = 0;
      repeat (400) begin
         @(negedge core_clk);
         tk1 += pwmTick[1];
      end
      chk("tkint", 9'h064, tk1[8:0]);
      finish_test;
   end
endmodule // tb_top
bind orc_overcurrent_retry orc_checker chk_i (.*);
